// ==== src/bdc_channel.v ====
// Summary of operation
// - busy set when buffered transfer starts
// - peripheral reply shown in status bit 9
// - peripheral reject shown in status bit 8
// - done never set while busy
// - busy falling sets done bit
// - direct functions other than abort rejected while busy
// - completion raises selected done interrupt line
// - done interrupt sets pending bit 2
// - done reads set when interrupt raised
// - first accepted word advances address to first
// - current address never decreases during output
// - abort function clears reserve bit
// - clear-reserve function clears reserve immediately
// - set-flag function sets addressed flags
// - clear-flag function clears addressed flags
// - mask and flag both set interrupt
// - flags appear in status bits 10-14
`timescale 1ns/10ps
`default_nettype none
`include "bdc_consts.vh"
module bdc_channel #(
    parameter DW = 16,
    parameter AW = 6
) (
    input wire clock,
    input wire sys_rst,
    // avalon-mm slave
    input wire [AW-1:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output wire [31:0] avs_readdata,
    output wire avs_waitrequest,
    output wire io_reject,
    // core memory port
    output wire [DW-1:0] mem_addr,
    output wire mem_rd,
    output wire mem_wr,
    output wire [DW-1:0] mem_wdata,
    input wire [DW-1:0] mem_rdata,
    input wire mem_ack,
    // peripheral controller
    output wire per_req,
    output wire per_dir_out,
    output wire [DW-1:0] per_wdata,
    input wire [DW-1:0] per_rdata,
    input wire per_reply,
    input wire per_reject,
    // interrupts
    output wire [DW-1:0] eop_irq,
    output wire flag_irq
);
    localparam ST_IDLE = 4'h1;
    localparam ST_MRD = 4'h2;
    localparam ST_PER = 4'h4;
    localparam ST_MWR = 4'h8;

    function [DW-1:0] inc;
        input [DW-1:0] a;
        begin
            inc = a + `BDC_ONE;
        end
    endfunction

    function [DW-1:0] onehot;
        input [`BDC_SEL_W-1:0] s;
        begin
            onehot = `BDC_ONE << s;
        end
    endfunction

    reg wait_r;
    reg [31:0] rdata_r;
    reg reject_r;
    reg [3:0] state_r;
    reg [3:0] state_nxt;
    reg busy_r;
    reg reserve_r;
    reg done_r;
    reg intpend_r;
    reg reply_r;
    reg rejbit_r;
    reg dir_out_r;
    reg eop_en_r;
    reg [`BDC_SEL_W-1:0] eop_sel_r;
    reg [`BDC_NFLAGS-1:0] flags_r;
    reg [`BDC_NFLAGS-1:0] mask_r;
    reg [DW-1:0] cur_addr_r;
    reg [DW-1:0] last_addr_r;
    reg [DW-1:0] word_r;
    reg mem_rd_r;
    reg [DW-1:0] mem_addr_r;
    reg mem_wr_r;
    reg per_req_r;
    reg [DW-1:0] eop_irq_r;
    reg flag_irq_r;
    reg reply_d_r;
    reg reject_d_r;

    wire [1:0] pin_sync;
    wire reply_s;
    wire reject_s;
    wire reply_rise;
    wire reject_rise;
    wire req;
    wire take;
    wire fn_abort;
    wire allowed;
    wire wr_ok;
    wire rd_ok;
    wire [DW-1:0] status;
    wire [DW-1:0] next_addr;
    wire last_word;
    wire finish;

    bdc_sync2 #(
        .W(2)
    ) u_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .async_in({per_reject, per_reply}),
        .sync_out(pin_sync)
    );

    assign reply_s = pin_sync[0];
    assign reject_s = pin_sync[1];
    assign reply_rise = reply_s & ~reply_d_r;
    assign reject_rise = reject_s & ~reject_d_r;

    // bus request accepted at the edge where waitrequest is low
    assign req = avs_read | avs_write;
    assign take = req & ~wait_r;
    assign fn_abort = avs_write && (avs_address == `BDC_OFS_FUNC) &&
        avs_writedata[`BDC_FN_ABORT];
    assign allowed = ~busy_r | fn_abort |
        (avs_read && ((avs_address == `BDC_OFS_STATUS) ||
        (avs_address == `BDC_OFS_CURADDR)));
    assign wr_ok = take & avs_write & allowed & avs_byteenable[0];
    assign rd_ok = avs_read & allowed;

    assign status = {1'b0, flags_r,
        reply_r, rejbit_r, 3'h0, done_r, reserve_r, intpend_r, busy_r, 1'b1};

    assign next_addr = inc(cur_addr_r);
    assign last_word = (next_addr == last_addr_r);
    assign finish = (state_r == ST_PER && reject_rise) ||
        (state_r == ST_PER && reply_rise && dir_out_r && last_word) ||
        (state_r == ST_MWR && mem_ack && last_word);

    // bus answer: one wait cycle, data registered
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wait_r <= 1'b1;
            rdata_r <= 32'h00000000;
            reject_r <= 1'b0;
        end else begin
            wait_r <= ~(req & wait_r);
            reject_r <= req & wait_r & ~allowed;
            if (req & wait_r) begin
                rdata_r <= 32'h00000000;
                if (rd_ok) begin
                    case (avs_address)
                        `BDC_OFS_STATUS: rdata_r[DW-1:0] <= status;
                        `BDC_OFS_CURADDR: rdata_r[DW-1:0] <= cur_addr_r;
                        `BDC_OFS_LASTADDR: rdata_r[DW-1:0] <= last_addr_r;
                        `BDC_OFS_MASK: rdata_r[`BDC_FLAG_HI:`BDC_FLAG_LO] <= mask_r;
                        `BDC_OFS_EOPSEL: rdata_r[`BDC_SEL_W-1:0] <= eop_sel_r;
                        default: rdata_r <= 32'h00000000;
                    endcase
                end
            end
        end
    end

    // transfer sequencer
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (wr_ok && avs_address == `BDC_OFS_START_OUT) begin
                    state_nxt = ST_MRD;
                end else if (wr_ok && avs_address == `BDC_OFS_START_IN) begin
                    state_nxt = ST_PER;
                end
            end
            ST_MRD: begin
                if (mem_ack) begin
                    state_nxt = ST_PER;
                end
            end
            ST_PER: begin
                if (reject_rise) begin
                    state_nxt = ST_IDLE;
                end else if (reply_rise && dir_out_r) begin
                    state_nxt = last_word ? ST_IDLE : ST_MRD;
                end else if (reply_rise) begin
                    state_nxt = ST_MWR;
                end
            end
            ST_MWR: begin
                if (mem_ack) begin
                    state_nxt = last_word ? ST_IDLE : ST_PER;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
        if (fn_abort & take) begin
            state_nxt = ST_IDLE;
        end
    end

    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= ST_IDLE;
            cur_addr_r <= `BDC_RST_WORD;
            last_addr_r <= `BDC_RST_WORD;
            word_r <= `BDC_RST_WORD;
            mem_addr_r <= `BDC_ONE;
            dir_out_r <= 1'b0;
            mem_rd_r <= 1'b0;
            mem_wr_r <= 1'b0;
            per_req_r <= 1'b0;
            reply_d_r <= 1'b0;
            reject_d_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            reply_d_r <= reply_s;
            reject_d_r <= reject_s;
            if (state_r == ST_IDLE && wr_ok &&
                (avs_address == `BDC_OFS_START_OUT || avs_address == `BDC_OFS_START_IN)) begin
                cur_addr_r <= avs_writedata[DW-1:0];
                mem_addr_r <= inc(avs_writedata[DW-1:0]);
                dir_out_r <= (avs_address == `BDC_OFS_START_OUT);
            end
            if (wr_ok && avs_address == `BDC_OFS_LASTADDR) begin
                last_addr_r <= avs_writedata[DW-1:0];
            end
            if (state_r == ST_MRD && mem_ack) begin
                word_r <= mem_rdata;
            end
            if (state_r == ST_PER && reply_rise) begin
                if (dir_out_r) begin
                    cur_addr_r <= next_addr;
                    mem_addr_r <= inc(next_addr);
                end else begin
                    word_r <= per_rdata;
                end
            end
            if (state_r == ST_MWR && mem_ack) begin
                cur_addr_r <= next_addr;
                mem_addr_r <= inc(next_addr);
            end
            mem_rd_r <= (state_nxt == ST_MRD) && !(state_r == ST_MRD && mem_ack);
            mem_wr_r <= (state_nxt == ST_MWR) && !(state_r == ST_MWR && mem_ack);
            per_req_r <= (state_nxt == ST_PER) && !(state_r == ST_PER &&
                (reply_rise | reject_rise));
        end
    end

    // status bits, flags, masks
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            busy_r <= 1'b0;
            reserve_r <= 1'b0;
            done_r <= 1'b0;
            intpend_r <= 1'b0;
            reply_r <= 1'b0;
            rejbit_r <= 1'b0;
            eop_en_r <= 1'b0;
            eop_sel_r <= `BDC_RST_SEL;
            flags_r <= `BDC_RST_FLAGS;
            mask_r <= `BDC_RST_FLAGS;
        end else begin
            if (wr_ok && avs_address == `BDC_OFS_FUNC) begin
                if (avs_writedata[`BDC_FN_CLRINT]) begin
                    intpend_r <= 1'b0;
                end
                if (avs_writedata[`BDC_FN_CLRRSV] | avs_writedata[`BDC_FN_ABORT]) begin
                    reserve_r <= 1'b0;
                end
                eop_en_r <= avs_writedata[`BDC_FN_EOPEN];
            end
            if (wr_ok && avs_address == `BDC_OFS_SETFLAG) begin
                flags_r <= flags_r | avs_writedata[`BDC_FLAG_HI:`BDC_FLAG_LO];
            end
            if (wr_ok && avs_address == `BDC_OFS_CLRFLAG) begin
                flags_r <= flags_r & ~avs_writedata[`BDC_FLAG_HI:`BDC_FLAG_LO];
            end
            if (wr_ok && avs_address == `BDC_OFS_MASK) begin
                mask_r <= avs_writedata[`BDC_FLAG_HI:`BDC_FLAG_LO];
            end
            if (wr_ok && avs_address == `BDC_OFS_EOPSEL) begin
                eop_sel_r <= avs_writedata[`BDC_SEL_W-1:0];
            end
            if (state_r == ST_IDLE && state_nxt != ST_IDLE) begin
                busy_r <= 1'b1;
                reserve_r <= 1'b1;
                done_r <= 1'b0;
                reply_r <= 1'b0;
                rejbit_r <= 1'b0;
            end
            if (busy_r && state_r == ST_PER && reply_rise) begin
                reply_r <= 1'b1;
            end
            if (busy_r && state_r == ST_PER && reject_rise) begin
                rejbit_r <= 1'b1;
            end
            if (busy_r && (finish || (fn_abort && take))) begin
                busy_r <= 1'b0;
                done_r <= 1'b1;
                if (eop_en_r) begin
                    intpend_r <= 1'b1;
                end
            end
        end
    end

    // interrupt outputs
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            eop_irq_r <= `BDC_RST_WORD;
            flag_irq_r <= 1'b0;
        end else begin
            eop_irq_r <= (intpend_r & done_r) ? onehot(eop_sel_r) : `BDC_RST_WORD;
            flag_irq_r <= |(mask_r & flags_r);
        end
    end

    assign avs_readdata = rdata_r;
    assign avs_waitrequest = wait_r;
    assign io_reject = reject_r;
    assign mem_addr = mem_addr_r;
    assign mem_rd = mem_rd_r;
    assign mem_wr = mem_wr_r;
    assign mem_wdata = word_r;
    assign per_req = per_req_r;
    assign per_dir_out = dir_out_r;
    assign per_wdata = word_r;
    assign eop_irq = eop_irq_r;
    assign flag_irq = flag_irq_r;
endmodule // bdc_channel
`default_nettype wire

// ==== pkg/bdc_consts.vh ====
`ifndef BDC_CONSTS_VH
`define BDC_CONSTS_VH

// register byte offsets
`define BDC_OFS_STATUS 6'h00
`define BDC_OFS_CURADDR 6'h04
`define BDC_OFS_START_OUT 6'h08
`define BDC_OFS_START_IN 6'h0c
`define BDC_OFS_LASTADDR 6'h10
`define BDC_OFS_FUNC 6'h14
`define BDC_OFS_SETFLAG 6'h18
`define BDC_OFS_CLRFLAG 6'h1c
`define BDC_OFS_MASK 6'h20
`define BDC_OFS_EOPSEL 6'h24

// status bit positions
`define BDC_ST_READY 0
`define BDC_ST_BUSY 1
`define BDC_ST_INTPEND 2
`define BDC_ST_RESERVE 3
`define BDC_ST_DONE 4
`define BDC_ST_REJECT 8
`define BDC_ST_REPLY 9
`define BDC_FLAG_LO 10
`define BDC_FLAG_HI 14

// function register bits
`define BDC_FN_CLRINT 0
`define BDC_FN_ABORT 1
`define BDC_FN_CLRRSV 2
`define BDC_FN_EOPEN 3

// field widths and reset values
`define BDC_NFLAGS 5
`define BDC_SEL_W 4
`define BDC_RST_WORD 16'h0000
`define BDC_RST_FLAGS 5'h00
`define BDC_RST_SEL 4'h4
`define BDC_ONE 16'h0001

`endif

// ==== src/bdc_sync2.v ====
`timescale 1ns/10ps
`default_nettype none
// two-flop synchroniser for asynchronous pins
module bdc_sync2 #(
    parameter W = 2
) (
    input wire clock,
    input wire sys_rst,
    input wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;

    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            meta_r <= {W{1'b0}};
            sync_r <= {W{1'b0}};
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;
endmodule // bdc_sync2
`default_nettype wire

// ==== verif/bdc_channel_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module bdc_channel_sva #(
    parameter DW = 16,
    parameter AW = 6
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic io_reject,
    input wire logic [DW-1:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic mem_ack,
    input wire logic per_req,
    input wire logic per_dir_out,
    input wire logic [DW-1:0] eop_irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    a_bus_answer_late: assert property ($rose(avs_read | avs_write) |=> !avs_waitrequest)
        else $error("late bus answer");
    a_reject_ack_zero: assert property (io_reject |-> !avs_waitrequest && avs_readdata == 32'h0)
        else $error("bad refusal");
    a_read_upper_zero: assert property (!avs_waitrequest |-> avs_readdata[31:16] == 16'h0)
        else $error("upper read bits set");
    a_mem_req_hold: assert property ((mem_rd | mem_wr) && !mem_ack |=>
        (mem_rd | mem_wr) && $stable(mem_addr)) else $error("memory request dropped");
    a_mem_dir_match: assert property ((mem_rd | mem_wr) |-> mem_rd == per_dir_out)
        else $error("memory direction wrong");
    a_eop_one_line: assert property (eop_irq != 16'h0 |-> $onehot(eop_irq))
        else $error("several done lines");
    a_eop_not_busy: assert property (per_req && $past(per_req) |-> eop_irq == 16'h0)
        else $error("done line while busy");
    a_dir_steady: assert property (per_req && $past(per_req) |-> $stable(per_dir_out))
        else $error("direction moved");
    c_refused: cover property (io_reject);
    c_done_line: cover property ($rose(eop_irq != 16'h0));
    c_mem_write: cover property (mem_wr && mem_ack);
endmodule // bdc_channel_sva
bind bdc_channel bdc_channel_sva #(.DW(DW), .AW(AW)) chk_u (.clock(clock), .sys_rst(sys_rst),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .io_reject(io_reject), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_ack(mem_ack), .per_req(per_req),
    .per_dir_out(per_dir_out), .eop_irq(eop_irq));
`default_nettype wire

// ==== verif/bdc_far_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// core memory and peripheral stand-in
module bdc_far_model (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic slow,
    input wire logic rej_en,
    input wire logic [15:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [15:0] mem_wdata,
    output var logic [15:0] mem_rdata,
    output var logic mem_ack,
    input wire logic per_req,
    input wire logic [15:0] per_wdata,
    output var logic [15:0] per_rdata,
    output var logic per_reply,
    output var logic per_reject,
    output var logic [15:0] last_out,
    output var logic [7:0] words
);
    logic [15:0] mem [0:255];
    logic [4:0] dly;
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            {mem_ack, per_reply, per_reject, dly, words} <= 16'h0;
            last_out <= 16'h0;
            mem_rdata <= 16'h0;
            per_rdata <= 16'h0;
        end else begin
            mem_ack <= (mem_rd | mem_wr) & ~mem_ack;
            mem_rdata <= mem_rd ? {8'ha5, mem_addr[7:0]} : ~mem_rdata;
            if (mem_wr & ~mem_ack)
                mem[mem_addr[7:0]] <= mem_wdata;
            if (!per_req) begin
                {per_reply, per_reject, dly} <= 7'h0;
                per_rdata <= ~per_rdata;
            end else if (!per_reply && !per_reject) begin
                dly <= dly + 5'h01;
                if (dly == (slow ? 5'h14 : 5'h02)) begin
                    per_reply <= !rej_en;
                    per_reject <= rej_en;
                    per_rdata <= 16'h3c00 + {8'h0, words};
                    last_out <= per_wdata;
                    words <= words + {7'h0, !rej_en};
                end
            end
        end
    end
endmodule // bdc_far_model
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(n,e,s) begin checked++; if ((s) !== (e)) begin failures++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb;
    logic clock, sys_rst, avs_read, avs_write, avs_waitrequest, io_reject, rj, slow, rej_en;
    logic mem_rd, mem_wr, mem_ack, per_req, per_dir_out, per_reply, per_reject, flag_irq;
    logic [5:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [15:0] mem_addr, mem_wdata, mem_rdata, per_wdata, per_rdata, eop_irq, q, st, pq, seed, first_word_address;
    logic [15:0] last_out;
    logic [7:0] words, w0;
    logic [4:0] f, m;
    integer failures = 0, checked = 0, cyc = 0, t, k;
    bdc_channel dut_u (.clock(clock), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .io_reject(io_reject), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .per_req(per_req),
        .per_dir_out(per_dir_out), .per_wdata(per_wdata), .per_rdata(per_rdata),
        .per_reply(per_reply), .per_reject(per_reject), .eop_irq(eop_irq), .flag_irq(flag_irq));
    bdc_far_model p_u (.clock(clock), .sys_rst(sys_rst), .slow(slow), .rej_en(rej_en),
        .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack), .per_req(per_req), .per_rdata(per_rdata),
        .per_reply(per_reply), .per_reject(per_reject), .words(words), .per_wdata(per_wdata),
        .last_out(last_out));
    function logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function logic [15:0] in_word(input logic [7:0] n);
        return 16'h3c00 + {8'h0, n};
    endfunction
    function logic [15:0] out_word(input logic [15:0] a);
        return {8'ha5, a[7:0]};
    endfunction
    task end_sim;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task bus(input logic w, input logic [5:0] a, input logic [15:0] d);
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= {16'h0, d};
        avs_read <= !w;
        avs_write <= w;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        q = avs_readdata[15:0];
        rj = io_reject;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task xfer(input logic din, input logic [3:0] n, input logic [3:0] sel);
        bus(1, 6'h10, first_word_address + {12'h0, n} - 16'h1);
        bus(1, 6'h24, {12'h0, sel});
        bus(1, 6'h14, 16'h0008);
        w0 = words;
        bus(1, din ? 6'h0c : 6'h08, first_word_address - 16'h1);
        bus(0, 6'h00, 16'h0);
        `CHK("busy", 1'b1, q[1]);
        `CHK("direction", !din, per_dir_out);
        bus(1, 6'h20, 16'h0);
        `CHK("refused", 1'b1, rj);
        if (slow && !din) begin
            for (k = 0; k < 300 && words == w0; k++) @(posedge clock);
            repeat (8) @(posedge clock);
            bus(0, 6'h04, 16'h0);
            `CHK("first addr", first_word_address, q);
        end
        pq = 16'h0;
        st = 16'h0002;
        for (k = 0; k < 300 && st[1]; k++) begin
            bus(0, 6'h00, 16'h0);
            st = q;
            `CHK("done with busy", 1'b0, st[1] & st[4]);
            `CHK("status refused", 1'b0, rj);
            if (!din) begin
                bus(0, 6'h04, 16'h0);
                `CHK("addr order", 1'b1, q >= pq);
                pq = q;
            end
        end
        `CHK("done", 1'b1, st[4]);
        `CHK("reply", !rej_en, st[9]);
        `CHK("reject", rej_en, st[8]);
        `CHK("pending", 1'b1, st[2]);
        repeat (2) @(posedge clock);
        `CHK("line", 16'h0001 << sel, eop_irq);
        bus(0, 6'h00, 16'h0);
        `CHK("done at line", 1'b1, q[4]);
        if (!rej_en) begin
            `CHK("count", {4'h0, n}, words - w0);
            bus(0, 6'h04, 16'h0);
            `CHK("end addr", first_word_address + {12'h0, n} - 16'h1, q);
            if (!din) `CHK("last out", out_word(first_word_address + {12'h0, n} - 16'h1), last_out);
            for (k = 0; k < n && din; k++)
                `CHK("data", in_word(w0 + k[7:0]), p_u.mem[first_word_address[7:0] + k[7:0]]);
        end
        bus(1, 6'h14, 16'h0005);
        bus(0, 6'h00, 16'h0);
        `CHK("reserve", 2'h0, {q[3], q[2]});
    endtask
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            end_sim;
        end
    end
    initial begin
        {sys_rst, avs_read, avs_write, slow, rej_en} = 5'h10;
        avs_address = 6'h0;
        avs_writedata = 32'h0;
        seed = 16'h0063;
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        bus(0, 6'h00, 16'h0);
        `CHK("reset status", 16'h0001, q);
        bus(0, 6'h3c, 16'h0);
        `CHK("unmapped", 17'h0, {rj, q});
        seed = lfsr(seed);
        f = seed[4:0] | 5'h01;
        m = seed[9:5];
        bus(1, 6'h18, {1'b0, f, 10'h0});
        bus(0, 6'h00, 16'h0);
        `CHK("flags set", f, q[14:10]);
        bus(1, 6'h1c, 16'h5400);
        bus(0, 6'h00, 16'h0);
        f = f & 5'h0a;
        `CHK("flags clear", f, q[14:10]);
        bus(1, 6'h20, {1'b0, m, 10'h0});
        repeat (2) @(posedge clock);
        `CHK("flag irq", |(m & f), flag_irq);
        bus(1, 6'h18, 16'h7c00);
        repeat (2) @(posedge clock);
        `CHK("flag irq all", |m, flag_irq);
        bus(1, 6'h1c, 16'h7c00);
        repeat (2) @(posedge clock);
        `CHK("flag irq off", 1'b0, flag_irq);
        for (t = 0; t < 5; t++) begin
            seed = lfsr(seed);
            first_word_address = {9'h0, seed[6:0]} + 16'h0010;
            slow = t[1] | (t == 4);
            rej_en = (t == 4);
            xfer(t[0] | rej_en, 4'h3 + {2'h0, seed[9:8]}, t == 3 ? 4'hf : seed[13:10]);
        end
        rej_en = 1'b0;
        bus(1, 6'h10, 16'h0040);
        bus(1, 6'h08, 16'h002f);
        bus(1, 6'h14, 16'h0002);
        `CHK("abort refused", 1'b0, rj);
        bus(0, 6'h00, 16'h0);
        `CHK("abort status", 2'h0, {q[3], q[1]});
        end_sim;
    end
endmodule // tb
`default_nettype wire
